// ==== hw/crbt_pkg.sv ====
// Purpose: Shared constants and types for the capture/reload/baud timer
// Assumes: APB slave with 32-bit data, one word per register
// Notes: Offsets are byte addresses
package crbt_pkg;
	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_COUNT_LOW = 8'h04;
	localparam logic [7:0] OFF_COUNT_HIGH = 8'h08;
	localparam logic [7:0] OFF_RELOAD_LOW = 8'h0C;
	localparam logic [7:0] OFF_RELOAD_HIGH = 8'h10;
	localparam logic [7:0] OFF_CLKDIV = 8'h14;
	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int B_CAP_RELOAD = 0;
	localparam int B_SRC = 1;
	localparam int B_RUN = 2;
	localparam int B_EXT_EN = 3;
	localparam int B_TX_BAUD = 4;
	localparam int B_RX_BAUD = 5;
	localparam int B_EXT_FLAG = 6;
	localparam int B_OVF_FLAG = 7;
	localparam int B_CLK_DIV = 5;
	// ************************************************************
	// Reset values and timing
	// ************************************************************
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CLKDIV_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [3:0] DIV12_LAST = 4'hB;
	localparam int SYS_CLK_MHZ = 200;
	// ************************************************************
	// Types
	// ************************************************************
	typedef enum {CRBT_OFF, CRBT_CAPTURE, CRBT_RELOAD, CRBT_BAUD} crbt_mode_t;
	typedef struct packed {
		logic rx_tick;
		logic tx_tick;
		logic adc_trigger;
		logic irq_req;
	} crbt_evt_t;
endpackage

// ==== hw/crbt_timer.sv ====
// Purpose: Sixteen-bit counter/timer with capture, auto-reload and baud modes
// Assumes: Pins are asynchronous to CLK_SYS; APB master holds requests until PREADY
// Notes: Zero wait states; unmapped reads return zero with PSLVERR low
`timescale 1ns/1ps

// How it works
// - Counter is two writable byte registers forming one 16-bit up-counter.
// - Source bit picks prescaled system clock or falling edges on count pin.
// - With baud bits clear and running, select bit picks capture or reload.
// - Counter only advances while run bit is set; otherwise off.
// - Capture mode: capture-pin falling edge copies count into reload register.
// - Capture/reload mode: rollover from FFFF sets overflow flag, requests interrupt.
// - Capture-pin edges are acted on only when external enable set.
// - Auto-reload mode: overflow loads reload value into counter.
// - Auto-reload mode: enabled capture-pin edge also loads reload value.
// - Either baud bit selects baud mode, reloading on overflow, ignoring select.
// - Baud mode overflow sets no flag; it drives UART shift clock.
// - Overflow ticks go to receiver and transmitter independently by bit.
// - Baud mode internal timebase is system clock divided by two only.
// - Baud mode with source bit set counts every second external count pin edge.
// - Baud mode enabled capture-pin edge sets external-edge flag, interrupt.
// - Timer event output serves as ADC conversion-start trigger.
// - Divide bit 0 gives system clock/12, 1 undivided; ignored otherwise.
module crbt_timer
(
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic EXT_COUNT_PIN,
	input wire logic EXT_CAPTURE_PIN,
	output crbt_pkg::crbt_evt_t EVENTS
);
	// ************************************************************
	// Pin synchronisers and edge detection
	// ************************************************************
	logic cnt_fall;
	logic cap_fall;
	logic pin_half_r;

	// Pins idle high; each falling edge gives one single-cycle event
	crbt_edge_sync #(.IDLE(1'b1)) count_edge_inst
	(
		.clk(CLK_SYS),
		.rst(RESET),
		.pin(EXT_COUNT_PIN),
		.fall(cnt_fall)
	);

	crbt_edge_sync #(.IDLE(1'b1)) capture_edge_inst
	(
		.clk(CLK_SYS),
		.rst(RESET),
		.pin(EXT_CAPTURE_PIN),
		.fall(cap_fall)
	);

	// ************************************************************
	// Registers and APB decode
	// ************************************************************
	logic [7:0] ctrl_r;
	logic [7:0] clkdiv_r;
	logic [15:0] count_r;
	logic [15:0] count_nxt;
	logic [15:0] reload_r;
	logic [15:0] reload_nxt;
	logic [3:0] div12_r;
	logic div2_r;
	logic ovf_set;
	logic ext_set;

	// Writes act only with the low byte lane enabled
	wire wr = PSEL && PENABLE && PWRITE && PSTRB[0];
	wire sel_ctrl = (PADDR == crbt_pkg::OFF_CTRL);
	wire sel_cl = (PADDR == crbt_pkg::OFF_COUNT_LOW);
	wire sel_ch = (PADDR == crbt_pkg::OFF_COUNT_HIGH);
	wire sel_rl = (PADDR == crbt_pkg::OFF_RELOAD_LOW);
	wire sel_rh = (PADDR == crbt_pkg::OFF_RELOAD_HIGH);
	wire sel_div = (PADDR == crbt_pkg::OFF_CLKDIV);
	wire wr_ctrl = wr && sel_ctrl;
	wire wr_cl = wr && sel_cl;
	wire wr_ch = wr && sel_ch;
	wire wr_rl = wr && sel_rl;
	wire wr_rh = wr && sel_rh;
	wire wr_div = wr && sel_div;

	// Unmapped offsets read as zero
	wire [7:0] rd_byte =
		sel_ctrl ? ctrl_r :
		sel_cl ? count_r[7:0] :
		sel_ch ? count_r[15:8] :
		sel_rl ? reload_r[7:0] :
		sel_rh ? reload_r[15:8] :
		sel_div ? (clkdiv_r & 8'h20) : 8'h00;

	// Only the low byte of each word carries data
	// Zero wait states: every access ends in its first access cycle
	assign PRDATA = {24'h000000, rd_byte};
	assign PREADY = 1'b1;
	assign PSLVERR = 1'b0;

	// ************************************************************
	// Mode decode
	// ************************************************************
	wire run = ctrl_r[crbt_pkg::B_RUN];
	wire baud_rx = ctrl_r[crbt_pkg::B_RX_BAUD];
	wire baud_tx = ctrl_r[crbt_pkg::B_TX_BAUD];
	wire ext_src = ctrl_r[crbt_pkg::B_SRC];
	wire ext_en = ctrl_r[crbt_pkg::B_EXT_EN];
	wire baud_any = baud_rx || baud_tx;
	wire cap_sel = ctrl_r[crbt_pkg::B_CAP_RELOAD];
	crbt_pkg::crbt_mode_t mode;

	// Run bit off overrides every other selection
	// Baud modes ignore the capture/reload select
	always_comb
	begin
		if (!run)
			mode = crbt_pkg::CRBT_OFF;
		else if (baud_any)
			mode = crbt_pkg::CRBT_BAUD;
		else if (cap_sel)
			mode = crbt_pkg::CRBT_CAPTURE;
		else
			mode = crbt_pkg::CRBT_RELOAD;
	end

	wire is_baud = (mode == crbt_pkg::CRBT_BAUD);
	wire ext_pair = is_baud && ext_src;

	// ************************************************************
	// Timebase
	// ************************************************************
	wire tick12 = (div12_r == crbt_pkg::DIV12_LAST);
	wire fast_tick = clkdiv_r[crbt_pkg::B_CLK_DIV] ? 1'b1 : tick12;
	wire int_tick = is_baud ? div2_r : fast_tick;
	// Pin edges are halved in baud mode, like the internal divide by two
	wire ext_tick = ext_pair ? (cnt_fall && pin_half_r) : cnt_fall;
	wire tick = (mode != crbt_pkg::CRBT_OFF) && (ext_src ? ext_tick : int_tick);
	wire ovf = tick && (count_r == crbt_pkg::COUNT_MAX);
	wire ext_evt = ext_en && cap_fall;

	wire [15:0] count_inc = count_r + 16'h0001;
	wire reload_hit = ovf || ext_evt;

	// Prescalers free-run so that a mode change never waits on them
	// Pin edge halving restarts whenever baud counting from the pin stops
	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
		begin
			div12_r <= 4'h0;
			div2_r <= 1'b0;
			pin_half_r <= 1'b0;
		end
		else
		begin
			div12_r <= tick12 ? 4'h0 : div12_r + 4'h1;
			div2_r <= ~div2_r;
			if (!ext_pair)
				pin_half_r <= 1'b0;
			else if (cnt_fall)
				pin_half_r <= ~pin_half_r;
		end
	end

	// ************************************************************
	// Counter, reload and flags
	// ************************************************************
	always_comb
	begin
		count_nxt = count_r;
		reload_nxt = reload_r;
		ovf_set = 1'b0;
		ext_set = 1'b0;
		if (wr_cl)
			count_nxt[7:0] = PWDATA[7:0];
		if (wr_ch)
			count_nxt[15:8] = PWDATA[7:0];
		if (wr_rl)
			reload_nxt[7:0] = PWDATA[7:0];
		if (wr_rh)
			reload_nxt[15:8] = PWDATA[7:0];
		// Hardware count update wins over a software write in the same cycle
		case (mode)
			crbt_pkg::CRBT_CAPTURE:
			begin
				if (tick)
					count_nxt = count_inc;
				if (ovf)
					ovf_set = 1'b1;
				if (ext_evt)
				begin
					reload_nxt = count_r;
					ext_set = 1'b1;
				end
			end
			crbt_pkg::CRBT_RELOAD:
			begin
				if (reload_hit)
					count_nxt = reload_r;
				else if (tick)
					count_nxt = count_inc;
				ovf_set = ovf;
				ext_set = ext_evt;
			end
			crbt_pkg::CRBT_BAUD:
			begin
				if (ovf)
					count_nxt = reload_r;
				else if (tick)
					count_nxt = count_inc;
				ext_set = ext_evt;
			end
			crbt_pkg::CRBT_OFF:
			begin
			end
			default:
			begin
			end
		endcase
	end

	// ************************************************************
	// Control register and flags
	// ************************************************************
	// Control holds the two flags in its top bits
	logic [7:0] flag_set;

	always_comb
	begin
		flag_set = 8'h00;
		flag_set[crbt_pkg::B_OVF_FLAG] = ovf_set;
		flag_set[crbt_pkg::B_EXT_FLAG] = ext_set;
	end

	// Hardware set wins over a software clear in the same cycle
	wire [7:0] ctrl_wr = wr_ctrl ? PWDATA[7:0] : ctrl_r;
	wire [7:0] ctrl_nxt = ctrl_wr | flag_set;
	wire flag_pending = ctrl_nxt[crbt_pkg::B_OVF_FLAG] || ctrl_nxt[crbt_pkg::B_EXT_FLAG];

	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
		begin
			ctrl_r <= crbt_pkg::CTRL_RESET;
			clkdiv_r <= crbt_pkg::CLKDIV_RESET;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			// Only the divide-select bit is kept
			if (wr_div)
				clkdiv_r <= PWDATA[7:0] & 8'h20;
		end
	end

	// Count and reload pairs; bytes are independent, with no latching
	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
		begin
			count_r <= crbt_pkg::COUNT_RESET;
			reload_r <= crbt_pkg::COUNT_RESET;
		end
		else
		begin
			count_r <= count_nxt;
			reload_r <= reload_nxt;
		end
	end

	// ************************************************************
	// Event outputs
	// ************************************************************
	// Ticks reach the UART side one cycle after the wrap
	crbt_pkg::crbt_evt_t evt_nxt;

	always_comb
	begin
		evt_nxt.rx_tick = is_baud && baud_rx && ovf;
		evt_nxt.tx_tick = is_baud && baud_tx && ovf;
		evt_nxt.adc_trigger = ovf;
		evt_nxt.irq_req = flag_pending;
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
			EVENTS <= '0;
		else
			EVENTS <= evt_nxt;
	end
endmodule

// ************************************************************
// Pin synchroniser with falling-edge detect
// ************************************************************
// Three stages; a change counts once stages two and three agree
module crbt_edge_sync
#(
	parameter logic IDLE = 1'b1
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic pin,
	output logic fall
);
	logic [2:0] sync_r;
	logic level_r;

	wire agree = (sync_r[1] == sync_r[2]);
	wire settled_low = agree && !sync_r[2];

	// Reset to the idle level so that no false edge follows reset
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sync_r <= {3{IDLE}};
			level_r <= IDLE;
		end
		else
		begin
			sync_r <= {sync_r[1:0], pin};
			if (agree)
				level_r <= sync_r[2];
		end
	end

	assign fall = settled_low && level_r;
endmodule

// ==== sim/crbt_timer_props.sv ====
// Purpose: Port checker for the capture/reload/baud timer
// Assumes: APB writes act with PSEL, PENABLE, PWRITE and PSTRB[0]
// Notes: Tracks the written control bits itself
`timescale 1ns/1ps
module crbt_timer_props
(
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire crbt_pkg::crbt_evt_t EVENTS
);
	logic [5:0] ctl_r;
	wire ca = PADDR == crbt_pkg::OFF_CTRL;
	wire wr = PSEL && PENABLE && PWRITE && PSTRB[0] && ca;
	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
			ctl_r <= 6'h00;
		else if (wr)
			ctl_r <= PWDATA[5:0];
	end
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RESET);
	sequence ctrl_steady;
		ca && $stable(PRDATA[7:6]);
	endsequence
	sequence stopped;
		(!ctl_r[2])[*3];
	endsequence
	sequence baud_on;
		(ctl_r[2] && ctl_r[5:4] != 2'b00)[*3];
	endsequence
	ready_high_a: assert property (PREADY)
		else $error("PREADY low");
	no_error_a: assert property (!PSLVERR)
		else $error("PSLVERR high");
	upper_zero_a: assert property (PRDATA[31:8] == 24'h000000)
		else $error("read data upper bits set");
	irq_flags_a: assert property (ctrl_steady[*2] |-> EVENTS.irq_req == |PRDATA[7:6])
		else $error("irq request differs from flags");
	rx_route_a: assert property (EVENTS.rx_tick |-> ctl_r[5] || $past(ctl_r[5]))
		else $error("rx tick without rx select");
	tx_route_a: assert property (EVENTS.tx_tick |-> ctl_r[4] || $past(ctl_r[4]))
		else $error("tx tick without tx select");
	tick_trigger_a: assert property ((EVENTS.rx_tick || EVENTS.tx_tick) |-> EVENTS.adc_trigger)
		else $error("tick without trigger");
	run_off_a: assert property (stopped |-> !EVENTS.adc_trigger)
		else $error("overflow while stopped");
	baud_noflag_a: assert property (baud_on ##0 (ca && $stable(PADDR)) |-> !$rose(PRDATA[7]))
		else $error("overflow flag in baud mode");
endmodule
bind crbt_timer crbt_timer_props crbt_timer_props_inst (.CLK_SYS(CLK_SYS), .RESET(RESET),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
	.PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .EVENTS(EVENTS));

// ==== sim/crbt_uart_model.sv ====
// Purpose: UART shift clock side and external pins
// Assumes: UART runs in its variable-rate modes 1 or 3
// Notes: Pins idle high; tasks make falling edges
`timescale 1ns/1ps
module crbt_uart_model
(
	input wire logic clk,
	input wire crbt_pkg::crbt_evt_t ev,
	output logic count_pin,
	output logic capture_pin,
	output int rx_ticks,
	output int tx_ticks,
	output int gap
);
	int now_c;
	int last;
	int rx_bits;
	assign rx_bits = rx_ticks / 16;
	initial
	begin
		count_pin = 1'b1;
		capture_pin = 1'b1;
		rx_ticks = 0;
		tx_ticks = 0;
		gap = 0;
		now_c = 0;
		last = 0;
	end
	always @(posedge clk)
	begin
		now_c++;
		rx_ticks += int'(ev.rx_tick === 1'b1);
		tx_ticks += int'(ev.tx_tick === 1'b1);
		if ((ev.rx_tick | ev.tx_tick) === 1'b1)
		begin
			gap = now_c - last;
			last = now_c;
		end
	end
	task automatic fall(input bit cap);
		@(posedge clk);
		if (cap)
			capture_pin <= 1'b0;
		else
			count_pin <= 1'b0;
		repeat (4) @(posedge clk);
		capture_pin <= 1'b1;
		count_pin <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
endmodule

// ==== sim/crbt_timer_tb.sv ====
// Purpose: Self-checking bench for the timer
// Assumes: Zero-wait APB slave
// Notes: Pins come from the partner model
`timescale 1ns/1ps
module crbt_timer_tb;
	logic CLK_SYS, RESET, PSEL, PENABLE, PWRITE;
	logic [7:0] PADDR, q;
	logic [31:0] PWDATA, PRDATA;
	logic [3:0] PSTRB;
	logic PREADY, PSLVERR;
	crbt_pkg::crbt_evt_t EVENTS;
	wire logic cnt_pin, cap_pin;
	int rx_ticks, tx_ticks, gap, fail_count, checked, n;
	crbt_timer crbt_timer_inst (.CLK_SYS(CLK_SYS), .RESET(RESET), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .EXT_COUNT_PIN(cnt_pin),
		.EXT_CAPTURE_PIN(cap_pin), .EVENTS(EVENTS));
	crbt_uart_model crbt_uart_model_inst (.clk(CLK_SYS), .ev(EVENTS), .count_pin(cnt_pin),
		.capture_pin(cap_pin), .rx_ticks(rx_ticks), .tx_ticks(tx_ticks), .gap(gap));
	initial
	begin
		CLK_SYS = 1'b0;
		forever #2.5 CLK_SYS = ~CLK_SYS;
	end
	task automatic complete_run();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e)
		begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
		@(posedge CLK_SYS);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= {24'h000000, d};
		PSTRB <= s;
		@(posedge CLK_SYS);
		PENABLE <= 1'b1;
		@(posedge CLK_SYS);
		while (PREADY !== 1'b1)
			@(posedge CLK_SYS);
		q = PRDATA[7:0];
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d, 4'hF);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00, 4'hF);
		chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, q});
	endtask
	task automatic stop();
		wr(crbt_pkg::OFF_CTRL, 8'h00);
		wr(crbt_pkg::OFF_CTRL, 8'h00);
	endtask
	task automatic load(input logic [7:0] rl, input logic [7:0] rh, input logic [7:0] ch);
		wr(crbt_pkg::OFF_RELOAD_LOW, rl);
		wr(crbt_pkg::OFF_RELOAD_HIGH, rh);
		wr(crbt_pkg::OFF_COUNT_LOW, rl);
		wr(crbt_pkg::OFF_COUNT_HIGH, ch);
	endtask
	initial
	begin
		repeat (20000) @(posedge CLK_SYS);
		fail_count++;
		complete_run();
	end
	initial
	begin
		RESET = 1'b1;
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA, PSTRB} = '0;
		repeat (20) @(posedge CLK_SYS);
		RESET <= 1'b0;
		rd(crbt_pkg::OFF_CTRL, crbt_pkg::CTRL_RESET);
		rd(crbt_pkg::OFF_CLKDIV, crbt_pkg::CLKDIV_RESET);
		rd(8'h18, 8'h00);
		wr(crbt_pkg::OFF_COUNT_LOW, 8'h5A);
		apb(1'b1, crbt_pkg::OFF_COUNT_LOW, 8'hA5, 4'h0);
		rd(crbt_pkg::OFF_COUNT_LOW, 8'h5A);
		$display("register test done");
		wr(crbt_pkg::OFF_CLKDIV, 8'h20);
		load(8'hF0, 8'hFF, 8'hFF);
		wr(crbt_pkg::OFF_CTRL, 8'h04);
		n = 0;
		while (EVENTS.adc_trigger !== 1'b1 && n < 100)
		begin
			@(posedge CLK_SYS);
			n++;
		end
		chk("adc", 16'h0001, {15'h0000, EVENTS.adc_trigger});
		rd(crbt_pkg::OFF_CTRL, 8'h84);
		rd(crbt_pkg::OFF_COUNT_HIGH, 8'hFF);
		stop();
		$display("reload test done");
		wr(crbt_pkg::OFF_CLKDIV, 8'h00);
		load(8'h00, 8'hAB, 8'h00);
		wr(crbt_pkg::OFF_CTRL, 8'h0C);
		crbt_uart_model_inst.fall(1'b1);
		rd(crbt_pkg::OFF_COUNT_HIGH, 8'hAB);
		wr(crbt_pkg::OFF_CTRL, 8'h05);
		wr(crbt_pkg::OFF_COUNT_HIGH, 8'h12);
		crbt_uart_model_inst.fall(1'b1);
		rd(crbt_pkg::OFF_RELOAD_HIGH, 8'hAB);
		wr(crbt_pkg::OFF_CTRL, 8'h0D);
		crbt_uart_model_inst.fall(1'b1);
		rd(crbt_pkg::OFF_RELOAD_HIGH, 8'h12);
		rd(crbt_pkg::OFF_CTRL, 8'h4D);
		stop();
		$display("capture test done");
		wr(crbt_pkg::OFF_CLKDIV, 8'h20);
		load(8'hFC, 8'hFF, 8'hFF);
		for (int k = 0; k < 2; k++)
		begin
			wr(crbt_pkg::OFF_CTRL, k ? 8'h15 : 8'h25);
			repeat (40) @(posedge CLK_SYS);
			chk("gap", 16'h0008, gap[15:0]);
			rd(crbt_pkg::OFF_CTRL, k ? 8'h15 : 8'h25);
			if (k == 0)
				chk("tx idle", 16'h0000, tx_ticks[15:0]);
		end
		chk("ticks", 16'h0001, 16'(rx_ticks > 3 && tx_ticks > 3));
		wr(crbt_pkg::OFF_CTRL, 8'h2C);
		crbt_uart_model_inst.fall(1'b1);
		rd(crbt_pkg::OFF_CTRL, 8'h6C);
		stop();
		load(8'hFE, 8'hFF, 8'hFF);
		n = rx_ticks;
		wr(crbt_pkg::OFF_CTRL, 8'h26);
		repeat (8) crbt_uart_model_inst.fall(1'b0);
		chk("pin ticks", 16'h0002, 16'(rx_ticks - n));
		stop();
		load(8'h00, 8'h00, 8'h00);
		wr(crbt_pkg::OFF_CTRL, 8'h06);
		repeat (3) crbt_uart_model_inst.fall(1'b0);
		stop();
		rd(crbt_pkg::OFF_COUNT_LOW, 8'h03);
		wr(crbt_pkg::OFF_CLKDIV, 8'h00);
		load(8'h00, 8'h00, 8'h00);
		wr(crbt_pkg::OFF_CTRL, 8'h04);
		repeat (120) @(posedge CLK_SYS);
		stop();
		apb(1'b0, crbt_pkg::OFF_COUNT_LOW, 8'h00, 4'hF);
		chk("div12", 16'h0001, 16'(q >= 8'h09 && q <= 8'h0B));
		$display("baud and counter test done");
		complete_run();
	end
endmodule
